// File: hw/lpc_codec.sv
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module lpc_codec (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        link_clk_in,
  input  wire logic        link_rst_b_in,
  input  wire logic [7:0]  rx_cad,
  input  wire logic        rx_ctl,
  output logic      [7:0]  tx_cad,
  output logic             tx_ctl,
  output logic             crc_check_en,
  output logic             rx_req_valid,
  output logic             rx_req_coherent,
  output logic      [4:0]  rx_reply_dwords
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic       lclk_s1, lclk_s2, lclk_s3;
  logic       lrst_s1, lrst_s2;
  logic [7:0] cad_s1, cad_s2;
  logic       ctl_s1, ctl_s2;

  // first stages are read only by second stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {lclk_s1, lclk_s2, lclk_s3} <= 3'b000;
      {lrst_s1, lrst_s2}          <= 2'b00;
      {cad_s1, cad_s2}            <= 16'h0000;
      {ctl_s1, ctl_s2}            <= 2'b00;
    end else if (ce) begin
      {lclk_s1, lclk_s2, lclk_s3} <= {link_clk_in, lclk_s1, lclk_s2};
      {lrst_s1, lrst_s2}          <= {link_rst_b_in, lrst_s1};
      {cad_s1, cad_s2}            <= {rx_cad, cad_s1};
      {ctl_s1, ctl_s2}            <= {rx_ctl, ctl_s1};
    end
  end

  // link is double data rate: each edge is one bit-time
  wire bt_tick  = lclk_s2 ^ lclk_s3;
  wire link_up  = lrst_s2;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, one wait state so read data comes from a flop
  logic       dph_q, ack_q, wr_q;
  logic [7:0] addr_q;
  wire        accept  = hsel & htrans[1] & hready;
  wire        wr_en   = dph_q & ~ack_q & wr_q;
  wire        rd_en   = dph_q & ~ack_q & ~wr_q;
  wire        sel_ctrl = addr_q == lpc_pkg::REG_CTRL;
  wire        sel_tag  = addr_q == lpc_pkg::REG_TAG;
  wire        sel_cmd  = addr_q == lpc_pkg::REG_CMD;
  wire        sel_alo  = addr_q == lpc_pkg::REG_ADDR_LO;
  wire        sel_ahi  = addr_q == lpc_pkg::REG_ADDR_HI;
  wire        sel_stat = addr_q == lpc_pkg::REG_STATUS;
  wire        sel_info = addr_q == lpc_pkg::REG_RXINFO;
  wire        sel_pkt  = (addr_q == lpc_pkg::REG_RXPKT0) | (addr_q == lpc_pkg::REG_RXPKT1);

  assign hreadyout = ~dph_q | ack_q;
  assign hresp     = 1'b0;

  // only whole-word accesses are expected, hsize is not checked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dph_q  <= 1'b0;
      ack_q  <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (ce) begin
      ack_q <= dph_q & ~ack_q;
      if (accept) begin
        dph_q  <= 1'b1;
        wr_q   <= hwrite;
        addr_q <= haddr[7:0];
      end else if (ack_q) begin
        dph_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  logic [3:0]              ctrl_q;
  logic [9:0]              tag_q;
  logic [lpc_pkg::CR_W-1:0] cmdr_q;
  logic [29:0]             alo_q;
  logic [7:0]              ahi_q;
  wire  tx_go     = wr_en & sel_ctrl & hwdata[lpc_pkg::CTRL_GO];
  wire  sync_go   = wr_en & sel_ctrl & hwdata[lpc_pkg::CTRL_SYNC];
  wire  rsp_mode  = ctrl_q[0];
  wire  peer_mode = ctrl_q[1];
  wire  [1:0] lwid = ctrl_q[3:2];
  wire  [4:0] own_tag   = tag_q[4:0];
  wire  [4:0] clump_lim = tag_q[9:5];

  // go bits are pulses and are not stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= lpc_pkg::CTRL_RST;
      tag_q  <= lpc_pkg::TAG_RST;
      cmdr_q <= lpc_pkg::CMD_RST;
      alo_q  <= 30'h00000000;
      ahi_q  <= 8'h00;
    end else if (ce && wr_en) begin
      if (sel_ctrl) ctrl_q <= hwdata[lpc_pkg::CTRL_WID+1:lpc_pkg::CTRL_RSP];
      if (sel_tag)  tag_q  <= hwdata[9:0];
      if (sel_cmd)  cmdr_q <= hwdata[lpc_pkg::CR_W-1:0];
      if (sel_alo)  alo_q  <= hwdata[31:2];
      if (sel_ahi)  ahi_q  <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit byte builder
  wire [5:0] c_cmd  = cmdr_q[lpc_pkg::CR_CMD+:6];
  wire [3:0] c_cnt  = cmdr_q[lpc_pkg::CR_CNT+:4];
  wire [3:0] c_seq  = cmdr_q[lpc_pkg::CR_SEQ+:4];
  wire [4:0] c_stag = cmdr_q[lpc_pkg::CR_STAG+:5];
  wire [4:0] c_rtag = cmdr_q[lpc_pkg::CR_RTAG+:5];
  wire       c_pw   = cmdr_q[lpc_pkg::CR_PASS_POSTED_FLAG];
  wire       c_post = c_cmd[lpc_pkg::CMD_POSTED];
  // bounced reply names us, peer-routed reply names requester
  wire [4:0] rsp_tag = peer_mode ? c_rtag : own_tag; // R3
  wire       rsp_brg = peer_mode; // R3
  wire [2:0] b2_low  = c_stag[2:0];
  wire [1:0] b2_mid  = c_post ? {cmdr_q[lpc_pkg::CR_DERR], cmdr_q[lpc_pkg::CR_CHAIN]}
                              : c_stag[4:3]; // R23
  wire [7:0] tx_b [8];

  // device only talks upstream; bounced peer traffic goes via host
  assign tx_b[0] = {c_seq[3:2], c_cmd}; // R11 R5
  assign tx_b[1] = rsp_mode ? {c_pw, rsp_brg, 1'b0, rsp_tag}
                            : {c_pw, c_seq[1:0], own_tag}; // R1
  assign tx_b[2] = rsp_mode ? {3'b000, c_stag}
                            : {c_cnt[1:0], cmdr_q[lpc_pkg::CR_COMPAT], b2_mid, b2_low}; // R13 R15
  assign tx_b[3] = rsp_mode ? 8'h00 : {alo_q[5:0], c_cnt[3:2]}; // R12 R19 R20
  assign tx_b[4] = alo_q[13:6]; // R12
  assign tx_b[5] = alo_q[21:14];
  assign tx_b[6] = alo_q[29:22];
  assign tx_b[7] = ahi_q;

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  lpc_pkg::lpc_tx_st_t tx_st_q;
  logic [3:0] tx_bt_q, tx_len_q;
  wire        tx_last = tx_bt_q == tx_len_q - 4'h1;

  // resync once started holds the link until link reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q  <= lpc_pkg::TX_IDLE;
      tx_bt_q  <= 4'h0;
      tx_len_q <= lpc_pkg::LEN_REQ;
    end else if (ce) begin
      unique case (tx_st_q)
        lpc_pkg::TX_IDLE: begin
          tx_bt_q <= 4'h0;
          if (sync_go && link_up) begin
            tx_st_q <= lpc_pkg::TX_SYNC; // R10
          end else if (tx_go && link_up) begin
            tx_st_q  <= lpc_pkg::TX_SEND;
            tx_len_q <= hwdata[lpc_pkg::CTRL_RSP] ? lpc_pkg::LEN_SHORT : lpc_pkg::LEN_REQ;
          end
        end
        lpc_pkg::TX_SEND: begin
          if (!link_up) begin
            tx_st_q <= lpc_pkg::TX_IDLE;
          end else if (sync_go) begin
            tx_st_q <= lpc_pkg::TX_SYNC; // R10
          end else if (bt_tick) begin
            tx_bt_q <= tx_bt_q + 4'h1;
            if (tx_last) tx_st_q <= lpc_pkg::TX_IDLE;
          end
        end
        lpc_pkg::TX_SYNC: begin
          if (!link_up) tx_st_q <= lpc_pkg::TX_IDLE; // R10
        end
        default: tx_st_q <= lpc_pkg::TX_IDLE;
      endcase
    end
  end

  // pins change only on link bit-times or link reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cad <= 8'h00;
      tx_ctl <= 1'b0;
    end else if (ce && (bt_tick || !link_up)) begin
      tx_ctl <= link_up & (tx_st_q != lpc_pkg::TX_IDLE);
      unique case (tx_st_q)
        lpc_pkg::TX_SYNC: tx_cad <= lpc_pkg::ALL_ONES; // R6
        lpc_pkg::TX_SEND: tx_cad <= tx_b[tx_bt_q[2:0]];
        default:          tx_cad <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive packet capture
  logic [3:0] rx_bt_q, rx_len_q;
  logic [5:0] r_cmd_q, r_alo_q;
  logic [4:0] r_tag_q;
  logic [3:0] r_cnt_q;
  logic       r_brg_q, rx_done_q;
  wire        rx_take  = bt_tick & ctl_s2 & link_up;
  wire        rx_first = rx_bt_q == 4'h0;
  wire [5:0]  new_cmd  = cad_s2[5:0];
  wire        new_long = (new_cmd[5:4] == 2'b01) | (new_cmd[4:3] == 2'b01);

  // a dropped control strobe mid-packet abandons it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_bt_q   <= 4'h0;
      rx_len_q  <= lpc_pkg::LEN_SHORT;
      r_cmd_q   <= 6'h00;
      r_tag_q   <= 5'h00;
      r_cnt_q   <= 4'h0;
      r_alo_q   <= 6'h00;
      r_brg_q   <= 1'b0;
      rx_done_q <= 1'b0;
    end else if (ce) begin
      rx_done_q <= rx_take & (rx_first ? new_long == 1'b0 && lpc_pkg::LEN_SHORT == 4'h1
                                       : rx_bt_q == rx_len_q - 4'h1);
      if (bt_tick && !ctl_s2) rx_bt_q <= 4'h0;
      if (rx_take) begin
        rx_bt_q <= (!rx_first && rx_bt_q == rx_len_q - 4'h1) ? 4'h0 : rx_bt_q + 4'h1;
        unique case (rx_bt_q)
          4'h0: begin
            r_cmd_q  <= new_cmd;
            rx_len_q <= new_long ? lpc_pkg::LEN_REQ : lpc_pkg::LEN_SHORT;
          end
          4'h1: begin
            r_tag_q <= cad_s2[4:0];
            r_brg_q <= cad_s2[lpc_pkg::RSP_BRIDGE];
          end
          4'h2: r_cnt_q[1:0] <= cad_s2[7:6];
          4'h3: {r_alo_q, r_cnt_q[3:2]} <= cad_s2; // R12
          default: ;
        endcase
      end
    end
  end

  logic [31:0] mem_rdata;
  lpc_pkt_mem u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .we    (rx_take),
    .waddr (rx_bt_q[2:0]),
    .wdata (cad_s2),
    .re    (accept),
    .raddr (haddr[2]),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive decode and checks, valid in the cycle after the last byte
  wire       is_sync = r_cmd_q == lpc_pkg::CMD_SYNC;
  wire       is_rd   = r_cmd_q[5:4] == 2'b01;
  wire       is_wr   = r_cmd_q[4:3] == 2'b01;
  wire       is_rsp  = (r_cmd_q[5:4] == 2'b11) & ~is_sync;
  wire       is_dw   = r_cmd_q[lpc_pkg::CMD_DWORD]; // R11
  wire       in_grp  = r_tag_q <= clump_lim; // R2
  wire [4:0] dw_end  = {1'b0, r_alo_q[3:0]} + {1'b0, r_cnt_q}; // R13
  wire [4:0] bw_end  = {2'b00, r_alo_q[2:0]} + {1'b0, r_cnt_q} - 5'h01; // R19 R20
  wire       dw_err  = (is_rd | is_wr) & is_dw & (dw_end > lpc_pkg::DW_BLK_LAST); // R14
  wire       bw_err  = is_wr & ~is_dw & (r_cnt_q != 4'h0) & (bw_end > lpc_pkg::BW_REG_LAST); // R18
  wire       bw_empty = is_wr & ~is_dw & (r_cnt_q == 4'h0); // R21
  wire       zmask   = is_rd & ~is_dw & (r_cnt_q == 4'h0); // R17 R22
  wire       req_any = is_rd | is_wr;
  wire [lpc_pkg::ST_N-1:0] st_set;
  // a byte read is one doubleword by construction, so it never splits
  assign st_set[lpc_pkg::ST_PKT]     = rx_done_q;
  assign st_set[lpc_pkg::ST_TAGERR]  = rx_done_q & is_rsp & ~in_grp; // R4 R1
  assign st_set[lpc_pkg::ST_BOUND]   = rx_done_q & (dw_err | bw_err); // R14 R18
  assign st_set[lpc_pkg::ST_ZMASK]   = rx_done_q & zmask;
  assign st_set[lpc_pkg::ST_BRIDGE]  = rx_done_q & is_rsp & ~r_brg_q; // R4
  assign st_set[lpc_pkg::ST_EMPTYBW] = rx_done_q & bw_empty;
  assign st_set[lpc_pkg::ST_PEER]    = rx_done_q & req_any & ~in_grp; // R1

  // reads are handed on, zero-mask ones too, with their reply size
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_req_valid    <= 1'b0;
      rx_req_coherent <= 1'b0;
      rx_reply_dwords <= 5'h00;
    end else if (ce) begin
      rx_req_valid <= rx_done_q & is_rd; // R17
      if (rx_done_q && is_rd) begin
        rx_req_coherent <= r_cmd_q[lpc_pkg::CMD_COH]; // R17
        rx_reply_dwords <= is_dw ? {1'b0, r_cnt_q} + 5'h01 : 5'h01; // R13 R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // resync detection and crc shutdown
  logic [6:0] ones_q;
  logic [2:0] sync_cmds_q;
  logic       sync_seen_q, crc_off_q;
  wire        lane_ones = (lwid == 2'b00) ? &cad_s2 :
                          (lwid == 2'b01) ? &cad_s2[3:0] : &cad_s2[1:0];
  wire [6:0]  ones_thr  = (lwid == 2'b00) ? lpc_pkg::SYNC_ONES :
                          (lwid == 2'b01) ? {lpc_pkg::SYNC_ONES[5:0], 1'b0}
                                          : {lpc_pkg::SYNC_ONES[4:0], 2'b00}; // R8
  wire        sync_hit  = (ones_q >= ones_thr) | (sync_cmds_q >= lpc_pkg::SYNC_CMDS); // R7

  // counters saturate; every link width accepts either the ones count or the command count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ones_q      <= 7'h00;
      sync_cmds_q <= 3'h0;
      {sync_seen_q, crc_off_q} <= 2'b00;
      crc_check_en <= 1'b0;
    end else if (ce) begin
      if (!link_up) begin
        ones_q      <= 7'h00;
        sync_cmds_q <= 3'h0;
        {sync_seen_q, crc_off_q} <= 2'b00;
      end else begin
        if (bt_tick) begin
          ones_q <= !lane_ones ? 7'h00 : (&ones_q ? ones_q : ones_q + 7'h01); // R7
        end
        if (rx_done_q) begin
          sync_cmds_q <= !is_sync ? 3'h0 :
                         (sync_cmds_q == lpc_pkg::SYNC_CMDS ? sync_cmds_q : sync_cmds_q + 3'h1);
        end
        if (sync_hit) sync_seen_q <= 1'b1; // R7
        if (rx_done_q && is_sync) crc_off_q <= 1'b1; // R9
      end
      crc_check_en <= link_up & ~crc_off_q & ~sync_seen_q & ~(rx_done_q & is_sync); // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags and read mux
  logic [lpc_pkg::ST_N-1:0] stat_q;
  wire  [lpc_pkg::ST_N-1:0] st_clr = (wr_en & sel_stat)
                                     ? hwdata[lpc_pkg::ST_FLAGS+:lpc_pkg::ST_N]
                                     : {lpc_pkg::ST_N{1'b0}};

  // set beats clear so a packet in the clear cycle is not lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= {lpc_pkg::ST_N{1'b0}};
    end else if (ce) begin
      stat_q <= (stat_q & ~st_clr) | st_set;
    end
  end

  wire [31:0] rd_stat = {22'h000000, stat_q, tx_st_q == lpc_pkg::TX_SYNC,
                         sync_seen_q, tx_st_q == lpc_pkg::TX_SEND};
  wire [31:0] rd_info = {7'h00, sync_cmds_q, r_brg_q, r_alo_q, r_cnt_q, r_tag_q, r_cmd_q};
  wire [31:0] rd_mux  = sel_ctrl ? {26'h0000000, ctrl_q, 2'b00} :
                        sel_tag  ? {22'h000000, tag_q} :
                        sel_cmd  ? {4'h0, cmdr_q} :
                        sel_alo  ? {alo_q, 2'b00} :
                        sel_ahi  ? {24'h000000, ahi_q} :
                        sel_stat ? rd_stat :
                        sel_info ? rd_info :
                        sel_pkt  ? mem_rdata : 32'h00000000;

  // read data loaded at the end of the wait state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (ce && rd_en) begin
      hrdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// File: common/lpc_pkg.sv
// What this block does
// R1: upstream request tag is our own
// R2: host group tag is zero or clumped peers
// R3: upstream reply tag and bridge flag per routing
// R4: downstream reply: responder tag, bridge flag set
// R5: bounced peer traffic is two separate transactions
// R6: resync pattern is all ones everywhere
// R7: resync by 16 ones bit-times or 4 commands
// R8: narrow links need 2x or 4x ones
// R9: stop checking crc once resync received
// R10: keep sending resync until link reset
// R11: command bit 2 selects byte or doubleword
// R12: address bits 39:2 in bit-times 3 to 7
// R13: count 0..15 means 1..16 ascending doublewords
// R14: doubleword requests never cross 64-byte blocks
// R15: mask bit 0 is the lowest byte
// R16: byte reads stay within one doubleword
// R17: zero-mask read still acts and gets reply
// R18: byte writes stay within 32-byte region
// R19: address 4:2 picks first doubleword in region
// R20: byte write count includes mask doubleword
// R21: byte write count nonzero except messages
// R22: unsent masks zero, zero masks still act
// R23: posted requests carry data error and chain
`default_nettype none
package lpc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_TAG     = 8'h04;
  localparam logic [7:0] REG_CMD     = 8'h08;
  localparam logic [7:0] REG_ADDR_LO = 8'h0c;
  localparam logic [7:0] REG_ADDR_HI = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_RXINFO  = 8'h18;
  localparam logic [7:0] REG_RXPKT0  = 8'h20;
  localparam logic [7:0] REG_RXPKT1  = 8'h24;
  // control register fields
  localparam int CTRL_GO   = 0;
  localparam int CTRL_SYNC = 1;
  localparam int CTRL_RSP  = 2;
  localparam int CTRL_PEER = 3;
  localparam int CTRL_WID  = 4;
  // tag register fields
  localparam int TAG_OWN   = 0;
  localparam int TAG_CLUMP = 5;
  // command register fields
  localparam int CR_CMD    = 0;
  localparam int CR_CNT    = 6;
  localparam int CR_SEQ    = 10;
  localparam int CR_PASS_POSTED_FLAG = 14;
  localparam int CR_COMPAT = 15;
  localparam int CR_DERR   = 16;
  localparam int CR_CHAIN  = 17;
  localparam int CR_STAG   = 18;
  localparam int CR_RTAG   = 23;
  localparam int CR_W      = 28;
  // reset values
  localparam logic [3:0]      CTRL_RST = 4'h0;
  localparam logic [9:0]      TAG_RST  = 10'h000;
  localparam logic [CR_W-1:0] CMD_RST  = 28'h0000000;
  // status sticky flags, write one to clear
  localparam int ST_PKT     = 0;
  localparam int ST_TAGERR  = 1;
  localparam int ST_BOUND   = 2;
  localparam int ST_ZMASK   = 3;
  localparam int ST_BRIDGE  = 4;
  localparam int ST_EMPTYBW = 5;
  localparam int ST_PEER    = 6;
  localparam int ST_N       = 7;
  localparam int ST_FLAGS   = 3;
  // packet encoding
  localparam logic [5:0] CMD_SYNC   = 6'h3f;
  localparam int         CMD_COH    = 0;
  localparam int         CMD_DWORD  = 2;
  localparam int         CMD_POSTED = 5;
  localparam int         RSP_BRIDGE = 6;
  localparam logic [7:0] ALL_ONES   = 8'hff;
  localparam logic [3:0] LEN_REQ    = 4'h8;
  localparam logic [3:0] LEN_SHORT  = 4'h4;
  // resync detection thresholds
  localparam logic [6:0] SYNC_ONES  = 7'h10;
  localparam logic [2:0] SYNC_CMDS  = 3'h4;
  // boundary limits in doublewords
  localparam logic [4:0] DW_BLK_LAST = 5'h0f;
  localparam logic [4:0] BW_REG_LAST = 5'h07;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_SYNC = 2'b10
  } lpc_tx_st_t;
endpackage
`default_nettype wire

// File: hw/lpc_pkt_mem.sv
`timescale 1ns/1ns
`default_nettype none
// captured control packet, byte write port, word read port
module lpc_pkt_mem (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       we,
  input  wire logic [2:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       re,
  input  wire logic       raddr,
  output logic      [31:0] rdata
);
  logic [7:0] mem_q [8];

  // storage has no reset, software reads after a packet flag
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // read data held in a register for the bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h00000000;
    end else if (ce && re) begin
      rdata <= {mem_q[{raddr, 2'b11}], mem_q[{raddr, 2'b10}],
                mem_q[{raddr, 2'b01}], mem_q[{raddr, 2'b00}]};
    end
  end
endmodule
`default_nettype wire

// File: dv/lpc_codec_props.sv
`timescale 1ns/1ns
`default_nettype none
module lpc_codec_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        link_clk_in,
  input wire logic        link_rst_b_in,
  input wire logic [7:0]  tx_cad,
  input wire logic        tx_ctl,
  input wire logic        crc_check_en,
  input wire logic        rx_req_valid,
  input wire logic [4:0]  rx_reply_dwords
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // bus side: two-cycle data phase, okay only
  wire take = hsel && htrans[1] && hready;
  property p_ok; hresp == 1'b0; endproperty
  a_ok: assert property (p_ok) else $error("hresp not okay");
  property p_wait; take |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("data phase length wrong");
  property p_hold; $changed(hrdata) |-> $past(hreadyout) == 1'b0; endproperty
  a_hold: assert property (p_hold) else $error("hrdata moved outside a data phase");
  ////////////////////////////////////////////////////////////////
  // receive side: request pulse and reply size
  property p_pulse; rx_req_valid |=> !rx_req_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("request pulse too long");
  property p_size; rx_req_valid |-> rx_reply_dwords inside {[5'h01:5'h10]}; endproperty
  a_size: assert property (p_size) else $error("reply size out of range");
  property p_keep; $changed(rx_reply_dwords) |-> rx_req_valid; endproperty
  a_keep: assert property (p_keep) else $error("reply size moved without request");
  ////////////////////////////////////////////////////////////////
  // link side: reset stops crc and transmit, bytes change only on edges
  property p_crc; (!link_rst_b_in) [*5] |-> !crc_check_en; endproperty
  a_crc: assert property (p_crc) else $error("crc check on in link reset");
  property p_lrst; (!link_rst_b_in) [*5] |-> !tx_ctl; endproperty
  a_lrst: assert property (p_lrst) else $error("transmit active in link reset");
  property p_bit;
    (link_rst_b_in && $stable(link_clk_in)) [*8] |=> $stable(tx_cad) && $stable(tx_ctl);
  endproperty
  a_bit: assert property (p_bit) else $error("tx moved without link edge");
endmodule
bind lpc_codec lpc_codec_props lpc_codec_props_inst (.clk, .rst_b, .hsel, .htrans, .hready,
  .hreadyout, .hresp, .hrdata, .link_clk_in, .link_rst_b_in, .tx_cad, .tx_ctl,
  .crc_check_en, .rx_req_valid, .rx_reply_dwords);
`default_nettype wire

// File: dv/lpc_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module lpc_far_end (
  output logic            link_clk_in,
  output logic      [7:0] rx_cad,
  output logic            rx_ctl,
  input  wire logic [7:0] tx_cad,
  input  wire logic       tx_ctl
);
  initial begin
    link_clk_in = 1'b0;
    rx_cad = 8'h00;
    rx_ctl = 1'b0;
  end
  // one bit-time; clock stands still between calls, a released lane flips
  task automatic bit_time(input logic [7:0] b, input logic c, output logic [8:0] t);
    rx_ctl = c;
    rx_cad = c ? b : ~rx_cad;
    #15;
    link_clk_in = ~link_clk_in;
    #45;
    t = {tx_ctl, tx_cad};
    #(2 + link_clk_in);
  endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, rst_b, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        link_clk_in, link_rst_b_in, rx_ctl, tx_ctl, crc_check_en;
  logic [7:0]  rx_cad, tx_cad;
  logic        rx_req_valid, rx_req_coherent, rv_coh;
  logic [4:0]  rx_reply_dwords, rv_dw;
  logic [8:0]  t;
  int          miscompares, checked, cyc, rv_n;
  lpc_codec lpc_codec_inst (.clk, .rst_b, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .link_clk_in, .link_rst_b_in, .rx_cad,
    .rx_ctl, .tx_cad, .tx_ctl, .crc_check_en, .rx_req_valid, .rx_req_coherent,
    .rx_reply_dwords);
  lpc_far_end lpc_far_end_inst (.link_clk_in, .rx_cad, .rx_ctl, .tx_cad, .tx_ctl);
  assign hready = hreadyout;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, runs need far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  // catch the one-cycle request pulse
  always @(posedge clk) if (rx_req_valid === 1'b1) begin
    rv_n++;
    rv_coh = rx_req_coherent;
    rv_dw = rx_reply_dwords;
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ready is looked at on the falling edge, inputs only move on rising
  task automatic rdy();
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    rd = hrdata;
    @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    rdy();
  endtask
  task automatic lrst();
    link_rst_b_in <= 1'b0;
    repeat (8) @(posedge clk);
    link_rst_b_in <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // n transmitted bit-times, then the line must go quiet
  task automatic tx_frame(input logic [63:0] e, input int n);
    for (int k = 0; k < n; k++) begin
      lpc_far_end_inst.bit_time(8'h00, 1'b0, t);
      chk({23'h0, t}, {24'h1, e[8*k +: 8]});
    end
    lpc_far_end_inst.bit_time(8'h00, 1'b0, t);
    chk({23'h0, t}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    ahb(1'b0, lpc_pkg::REG_CTRL, 32'h0); chk(rd, 32'h0);
    ahb(1'b0, lpc_pkg::REG_TAG, 32'h0); chk(rd, 32'h0);
    ahb(1'b1, 8'h1c, 32'hffffffff); ahb(1'b0, 8'h1c, 32'h0); chk(rd, 32'h0);
    $display("regs done");
  endtask
  // plain dword read, then posted write with data error and no chain
  task automatic t_req();
    ahb(1'b1, lpc_pkg::REG_TAG, 32'h5);
    ahb(1'b1, lpc_pkg::REG_ADDR_LO, 32'h12345640);
    ahb(1'b1, lpc_pkg::REG_ADDR_HI, 32'h9a);
    for (int i = 0; i < 2; i++) begin
      ahb(1'b1, lpc_pkg::REG_CMD, i ? 32'h03a964ec : 32'h03a864d4);
      ahb(1'b1, lpc_pkg::REG_CTRL, 32'h1);
      tx_frame(i ? 64'h9a12345640d2a5ac : 64'h9a12345640caa594, 8);
    end
    $display("request done");
  endtask
  // reply bounced through host, then direct-peer routed
  task automatic t_rsp();
    ahb(1'b1, lpc_pkg::REG_CMD, 32'h03a864d4);
    for (int p = 0; p < 2; p++) begin
      ahb(1'b1, lpc_pkg::REG_CTRL, p ? 32'hd : 32'h5);
      tx_frame(p ? 64'h000ac794 : 64'h000a8594, 4);
    end
    $display("reply done");
  endtask
  // resync keeps going through a send request until link reset
  task automatic t_sync_tx();
    ahb(1'b1, lpc_pkg::REG_CTRL, 32'h2);
    for (int k = 0; k < 12; k++) begin
      if (k == 6) ahb(1'b1, lpc_pkg::REG_CTRL, 32'h1);
      lpc_far_end_inst.bit_time(8'h00, 1'b0, t);
      chk({23'h0, t}, 32'h1ff);
    end
    lrst();
    chk({23'h0, tx_ctl, tx_cad}, 32'h0);
    $display("resync send done");
  endtask
  // fifteen ones bit-times fall short, sixteen are enough
  task automatic t_sync_rx();
    for (int n = 15; n < 17; n++) begin
      lrst();
      chk({31'h0, crc_check_en}, 32'h1);
      for (int k = 0; k < n; k++) begin
        lpc_far_end_inst.bit_time(8'hff, 1'b1, t);
        if (k == 4) chk({31'h0, crc_check_en}, 32'h0);
      end
      lpc_far_end_inst.bit_time(8'h00, 1'b0, t);
      ahb(1'b0, lpc_pkg::REG_STATUS, 32'h0);
      chk({31'h0, rd[1]}, n - 15);
    end
    $display("resync detect done");
  endtask
  // zero-mask coherent byte read, then full sixteen dword read
  task automatic t_rx();
    logic [63:0] p;
    lrst();
    for (int i = 0; i < 2; i++) begin
      p = i ? 64'h03c00014 : 64'h11;
      for (int k = 0; k < 8; k++) lpc_far_end_inst.bit_time(p[8*k +: 8], 1'b1, t);
      lpc_far_end_inst.bit_time(8'h00, 1'b0, t);
      chk(rv_n, i + 1);
      chk({31'h0, rv_coh}, i ? 32'h0 : 32'h1);
      chk({27'h0, rv_dw}, i ? 32'h10 : 32'h1);
      ahb(1'b0, lpc_pkg::REG_STATUS, 32'h0);
      if (i == 0) chk({31'h0, rd[6]}, 32'h1);
    end
    $display("receive done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; link_rst_b_in = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    lrst();
    t_regs();
    t_req();
    t_rsp();
    t_sync_tx();
    t_sync_rx();
    t_rx();
    complete_run();
  end
endmodule
`default_nettype wire
